//--- hw/raster_display.v
/*
 * Eight-plane raster display generator: sync timing, plane memories with
 * nibble shift registers, palette, host access and end-of-frame pulse.
 * Assumes one clock, a single-cycle host strobe and an external DAC.
 */
`timescale 1ns/1ns
`include "raster_map.vh"
module raster_display #(
    // Clocks per pixel less one; 7 keeps the frame at 60 Hz at 125 MHz
    parameter PIX_DIV = 7
) (
    // Clock and reset
    input  wire        clk_sys,
    input  wire        rst,
    // Host bus
    input  wire        host_req,
    input  wire        host_we,
    input  wire [23:0] host_addr,
    input  wire [2:0]  host_psel,
    input  wire        host_psel_en,
    input  wire [31:0] host_wdata,
    output reg  [31:0] host_rdata,
    output reg         host_ack,
    // Monitor
    output reg         hsync,
    output reg         vsync,
    output reg  [7:0]  red,
    output reg  [7:0]  green,
    output reg  [7:0]  blue,
    // Interrupt
    output reg         eof_irq
);

localparam H_TOT = `ACT_PIX + `H_FRONT + `H_SYNC + `H_BACK;
localparam V_TOT = `ACT_LINES + `V_FRONT + `V_SYNC + `V_BACK;
localparam NIBS  = `ACT_PIX / `NIB_W;
localparam HS_ON  = `ACT_PIX + `H_FRONT;
localparam HS_OFF = `ACT_PIX + `H_FRONT + `H_SYNC;
localparam VS_ON  = `ACT_LINES + `V_FRONT;
localparam VS_OFF = `ACT_LINES + `V_FRONT + `V_SYNC;

////////////////////////////////////////////////////////////////////////////
// Pixel clock enable derived from the system clock
reg [3:0]  div_r;
reg [9:0]  hcnt_r;
reg [9:0]  vcnt_r;
wire       pix_tick = (div_r == PIX_DIV[3:0]);

function in_range;
    input [9:0] v;
    input [9:0] lo;
    input [9:0] hi;
    begin
        in_range = (v >= lo) && (v < hi);
    end
endfunction

wire h_act = (hcnt_r < `ACT_PIX);
wire v_act = (vcnt_r < `ACT_LINES);

always @(posedge clk_sys) begin
    if (rst) begin
        div_r  <= 4'h0;
        hcnt_r <= 10'h000;
        vcnt_r <= 10'h000;
    end else begin
        div_r <= pix_tick ? 4'h0 : div_r + 4'h1;
        if (pix_tick) begin
            if (hcnt_r == H_TOT - 1) begin
                hcnt_r <= 10'h000;
                vcnt_r <= (vcnt_r == V_TOT - 1) ? 10'h000 : vcnt_r + 10'h001;
            end else begin
                hcnt_r <= hcnt_r + 10'h001;
            end
        end
    end
end

////////////////////////////////////////////////////////////////////////////
// Plane memories, one nibble per location per plane
reg [`NIB_W-1:0] mem0 [0:65535];
reg [`NIB_W-1:0] mem1 [0:65535];
reg [`NIB_W-1:0] mem2 [0:65535];
reg [`NIB_W-1:0] mem3 [0:65535];
reg [`NIB_W-1:0] mem4 [0:65535];
reg [`NIB_W-1:0] mem5 [0:65535];
reg [`NIB_W-1:0] mem6 [0:65535];
reg [`NIB_W-1:0] mem7 [0:65535];

// Refresh address: one nibble per four pixels of the active line
wire [15:0] fetch_addr = vcnt_r * NIBS[15:0] + {8'h00, hcnt_r[9:2]};
// Last line of the frame wraps to the first active line
wire next_act = (vcnt_r == V_TOT - 1) || (vcnt_r < `ACT_LINES - 1);
wire line_end = (hcnt_r == H_TOT - 2);
// Fetch one pixel ahead of the group boundary, so that the shifters
// load on the boundary itself and no stale pixel reaches the palette
wire fetch = pix_tick && (hcnt_r[1:0] == 2'h2) &&
             (line_end ? next_act : (h_act && v_act));
wire [15:0] raddr = fetch ? (line_end ?
             (vcnt_r == V_TOT - 1 ? 16'h0000 :
              (vcnt_r + 10'h001) * NIBS[15:0]) : fetch_addr + 16'h0001)
             : host_addr[17:2];

reg  [31:0] fetch_q;
reg  [31:0] sh_r;

wire sel_mem = host_addr[`DEC_HI:`DEC_LO] == `DEC_DISPLAY;
wire sel_pal = host_psel_en && host_psel == `PSEL_PALETTE
               && !sel_mem;
reg         pend_r;

always @(posedge clk_sys) begin
    // Held until the boundary, as host reads reuse the same port
    if (fetch)
        fetch_q <= {mem7[raddr], mem6[raddr], mem5[raddr], mem4[raddr],
                    mem3[raddr], mem2[raddr], mem1[raddr],
                    mem0[raddr]};
    if (!fetch && (host_req || pend_r) && sel_mem && host_we) begin
        mem0[raddr] <= host_wdata[3:0];
        mem1[raddr] <= host_wdata[7:4];
        mem2[raddr] <= host_wdata[11:8];
        mem3[raddr] <= host_wdata[15:12];
        mem4[raddr] <= host_wdata[19:16];
        mem5[raddr] <= host_wdata[23:20];
        mem6[raddr] <= host_wdata[27:24];
        mem7[raddr] <= host_wdata[31:28];
    end
end

////////////////////////////////////////////////////////////////////////////
// Nibble shifters: load on each group boundary, else shift once a pixel
integer i;
always @(posedge clk_sys) begin
    if (rst) begin
        sh_r <= 32'h00000000;
    end else if (pix_tick) begin
        if (hcnt_r[1:0] == 2'h3) begin
            sh_r <= fetch_q;
        end else begin
            for (i = 0; i < 8; i = i + 1)
                sh_r[i*4 +: 4] <= {sh_r[i*4 +: 3], 1'b0};
        end
    end
end

// Eight-bit colour index, one bit from each plane
wire [7:0] pix_idx = {sh_r[31], sh_r[27], sh_r[23], sh_r[19],
                      sh_r[15], sh_r[11], sh_r[7], sh_r[3]};

////////////////////////////////////////////////////////////////////////////
// Palette: 256 entries of 24-bit RGB
reg [23:0] pal [0:255];
reg [23:0] pal_q;
reg        act_d_r;

always @(posedge clk_sys) begin
    pal_q <= pal[pix_idx];
    if (host_req && sel_pal && host_we)
        pal[host_addr[9:2]] <= host_wdata[23:0];
end

////////////////////////////////////////////////////////////////////////////
// Host handshake, syncs, colour outputs and frame pulse
always @(posedge clk_sys) begin
    if (rst) begin
        pend_r     <= 1'b0;
        host_ack   <= 1'b0;
        host_rdata <= 32'h00000000;
        hsync      <= 1'b0;
        vsync      <= 1'b0;
        red        <= 8'h00;
        green      <= 8'h00;
        blue       <= 8'h00;
        eof_irq    <= 1'b0;
        act_d_r    <= 1'b0;
    end else begin
        host_ack <= 1'b0;
        // A memory access that meets a fetch waits one cycle; the host
        // must hold address and data and issue nothing new until ack
        if (host_req && sel_mem && fetch)
            pend_r <= 1'b1;
        if ((host_req || pend_r) && sel_mem && !fetch) begin
            pend_r     <= 1'b0;
            host_ack   <= 1'b1;
            host_rdata <= {mem7[raddr], mem6[raddr], mem5[raddr],
                           mem4[raddr], mem3[raddr], mem2[raddr],
                           mem1[raddr], mem0[raddr]};
        end else if (host_req && sel_pal) begin
            host_ack   <= 1'b1;
            host_rdata <= {8'h00, pal[host_addr[9:2]]};
        end else if (host_req && !sel_mem) begin
            host_ack   <= 1'b1;
            host_rdata <= 32'h00000000;
        end
        hsync <= in_range(hcnt_r, HS_ON[9:0], HS_OFF[9:0]);
        vsync <= in_range(vcnt_r, VS_ON[9:0], VS_OFF[9:0]);
        act_d_r <= h_act && v_act;
        if (act_d_r) begin
            red   <= pal_q[23:16];
            green <= pal_q[15:8];
            blue  <= pal_q[7:0];
        end else begin
            red   <= 8'h00;
            green <= 8'h00;
            blue  <= 8'h00;
        end
        eof_irq <= pix_tick && hcnt_r == H_TOT - 1
                   && vcnt_r == `ACT_LINES - 1;
    end
end

endmodule // raster_display

//--- pkg/raster_map.vh
/*
 * Timing, geometry and address-decode constants for the raster display.
 * Assumes a 125 MHz system clock and a 24-bit host byte address.
 */
`ifndef RASTER_MAP_VH
`define RASTER_MAP_VH

// Active area
`define ACT_PIX        576
`define ACT_LINES      368
// Blanking, chosen so that a frame lasts one sixtieth of a second:
// 664 x 392 pixels of eight clocks each come to 60.03 Hz at 125 MHz.
// The line total must stay a multiple of four for the nibble fetch.
`define H_FRONT        16
`define H_SYNC         40
`define H_BACK         32
`define V_FRONT        3
`define V_SYNC         4
`define V_BACK         17
`define FRAME_RATE_HZ  60
`define CLK_HZ         125000000
// Host decode: top three address bits
`define DEC_HI         23
`define DEC_LO         21
`define DEC_DISPLAY    3'h5
// Peripheral select code of the palette
`define PSEL_PALETTE   3'h3
// Planes and memory shape
`define PLANES         8
`define MEM_AW         16
`define NIB_W          4

`endif

//--- test/monitor_model.sv
/* Monitor model: measures line period and sync width.
   Assumes active high sync from the display. */
`timescale 1ns/1ns
module monitor_model (
    input wire          clk_sys,
    input wire          rst,
    input wire          hsync,
    output logic [15:0] period,
    output logic [15:0] width
);
    logic [15:0] cnt_r, hi_r;
    logic        hs_r;
    always @(posedge clk_sys) begin
        hs_r <= hsync;
        cnt_r <= (hsync && !hs_r) ? 16'h1 : cnt_r + 16'h1;
        hi_r <= hsync ? hi_r + 16'h1 : 16'h0;
        if (hsync && !hs_r)
            period <= cnt_r;
        if (!hsync && hs_r)
            width <= hi_r;
        if (rst)
            period <= 16'h0;
    end
endmodule // monitor_model

//--- test/raster_display_assertions.sv
/* Port checker for raster_display.
   Assumes the bind below and one clock. */
`timescale 1ns/1ns
`include "raster_map.vh"
module raster_chk #(parameter PIX_DIV = 9) (
    input wire       clk_sys, rst, host_req, host_ack,
    input wire       hsync, vsync, eof_irq,
    input wire [7:0] red, green, blue
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (rst);
    logic [15:0] lcnt_r, wcnt_r;
    logic        hs_r, seen_r;
    wire         blk = (red | green | blue) == 8'h00;
    always @(posedge clk_sys) begin
        hs_r <= hsync;
        wcnt_r <= hsync ? wcnt_r + 16'h1 : 16'h0;
        lcnt_r <= (hsync && !hs_r) ? 16'h1 : lcnt_r + 16'h1;
        if (hsync && !hs_r)
            seen_r <= 1'b1;
        if (rst)
            seen_r <= 1'b0;
    end
    a_ack_in_time: assert property (host_req |-> ##[1:2] host_ack)
        else $error("ack late");
    a_ack_single: assert property (host_ack |=> !host_ack)
        else $error("ack long");
    a_ack_has_cause: assert property (host_ack |->
        $past(host_req) || $past(host_req, 2)) else $error("ack uncaused");
    a_blank_hsync: assert property (hsync |-> blk)
        else $error("colour in hsync");
    a_blank_vsync: assert property (vsync |-> blk)
        else $error("colour in vsync");
    a_eof_pulse: assert property (eof_irq |=> !eof_irq)
        else $error("eof long");
    a_line_period: assert property ($rose(hsync) && seen_r |->
        lcnt_r == (`ACT_PIX + `H_FRONT + `H_SYNC + `H_BACK) * (PIX_DIV + 1))
        else $error("line period");
    a_sync_width: assert property ($fell(hsync) |->
        wcnt_r == `H_SYNC * (PIX_DIV + 1)) else $error("sync width");
    c_ack: cover property (host_ack);
    c_line: cover property ($rose(hsync) && seen_r);
    c_colour: cover property (!blk);
endmodule // raster_chk
bind raster_display raster_chk #(.PIX_DIV(PIX_DIV)) i_chk (.clk_sys, .rst,
    .host_req, .host_ack, .hsync, .vsync, .eof_irq, .red, .green, .blue);

//--- test/tb.sv
/* Bench for raster_display: random host traffic, line timing.
   Assumes the checker bind and monitor_model. */
`timescale 1ns/1ns
`include "raster_map.vh"
module tb;
    localparam PD = 3;
    localparam NG = `ACT_PIX / `NIB_W;
    int          nrise = 0;
    logic        clk_sys = 0, rst = 1, host_req = 0, host_we = 0;
    logic        host_psel_en = 0, host_ack, hsync, vsync, eof_irq;
    logic [2:0]  host_psel = 0;
    logic [23:0] host_addr = 0;
    logic [31:0] host_wdata = 0, host_rdata, q;
    logic [7:0]  red, green, blue;
    logic [15:0] period, width;
    int          miscompares = 0, num_checks = 0;
    raster_display #(.PIX_DIV(PD)) i_dut (.clk_sys, .rst, .host_req,
        .host_we, .host_addr, .host_psel, .host_psel_en, .host_wdata,
        .host_rdata, .host_ack, .hsync, .vsync, .red, .green, .blue,
        .eof_irq);
    monitor_model i_mon (.clk_sys, .rst, .hsync, .period, .width);
    // Rise n of hsync after reset falls in line n-1
    always @(posedge hsync)
        nrise++;
    initial forever #4 clk_sys = ~clk_sys;
    function logic [15:0] cyc(input int px);
        return px * (PD + 1);
    endfunction
    task chk(input string nm, input logic [31:0] e, input logic [31:0] s);
        num_checks++;
        if (s !== e) begin
            miscompares++;
            $display("mismatch %s exp %h got %h", nm, e, s);
        end
    endtask
    // Request held one cycle; ack may slip a cycle behind refresh
    task hcyc(input logic we, pen, input logic [2:0] ps,
              input logic [23:0] a, input logic [31:0] d);
        int n;
        host_we = we;
        host_psel_en = pen;
        host_psel = ps;
        host_addr = a;
        host_wdata = d;
        host_req = 1;
        @(posedge clk_sys);
        #1 host_req = 0;
        for (n = 0; n < 3 && host_ack !== 1'b1; n++) begin
            @(posedge clk_sys);
            #1;
        end
        q = host_rdata;
        chk("ack", 1, host_ack);
        @(posedge clk_sys);
        #1;
    endtask
    task finish_test;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #480000;
        miscompares++;
        finish_test;
    end
    initial begin
        logic [23:0] a[8], p[8];
        logic [31:0] d[8];
        logic [23:0] c0, c1;
        int          ln, n0, n1, nx;
        void'($urandom(56673));
        repeat (8) @(posedge clk_sys);
        #1 rst = 0;
        chk("hsync", 0, hsync);
        for (int i = 0; i < 8; i++) begin
            a[i] = {3'h5, 3'h0, 13'($urandom), 3'(i), 2'h0};
            p[i] = {14'h0, 5'($urandom), 3'(i), 2'h0};
            d[i] = $urandom;
            hcyc(1, 0, 0, a[i], d[i]);
            hcyc(1, 1, 3'h3, p[i], ~d[i]);
        end
        for (int i = 0; i < 8; i++) begin
            hcyc(0, 0, 0, a[i], 0);
            chk("mem", d[i], q);
            hcyc(0, 1, 3'h3, p[i], 0);
            chk("pal", {8'h00, ~d[i][23:0]}, q);
        end
        hcyc(0, 0, 0, 24'h400000, 0);
        chk("unmapped", 0, q);
        hcyc(0, 1, 3'h1, 24'h000004, 0);
        chk("other psel", 0, q);
        $display("host test done");
        repeat (2) @(posedge hsync);
        repeat (2) @(posedge clk_sys);
        chk("period", cyc(`ACT_PIX + `H_FRONT + `H_SYNC + `H_BACK), period);
        chk("width", cyc(`H_SYNC), width);
        $display("line test done");
        // Whole line of nibble 1010 in every plane: indices FF and 00
        @(posedge hsync);
        #1;
        ln = nrise + 1;
        c0 = {1'b0, 7'($urandom) | 7'h01, 16'($urandom)};
        c1 = {1'b1, 23'($urandom)};
        hcyc(1, 1, 3'h3, 24'h000000, {8'h00, c0});
        hcyc(1, 1, 3'h3, 24'h0003FC, {8'h00, c1});
        for (int k = 0; k < NG; k++)
            hcyc(1, 0, 0, {3'h5, 3'h0, 16'(ln * NG + k), 2'h0},
                 32'hAAAAAAAA);
        @(posedge hsync);
        n0 = 0;
        n1 = 0;
        nx = 0;
        repeat (cyc(`ACT_PIX + `H_FRONT + `H_SYNC + `H_BACK)) begin
            @(posedge clk_sys);
            #1;
            if ({red, green, blue} === c1)
                n1++;
            else if ({red, green, blue} === c0)
                n0++;
            else if ({red, green, blue} !== 24'h000000)
                nx++;
        end
        chk("pixels ff", cyc(`ACT_PIX / 2), n1);
        chk("pixels 00", cyc(`ACT_PIX / 2), n0);
        chk("pixels other", 0, nx);
        chk("vsync", 0, vsync);
        $display("colour test done");
        finish_test;
    end
endmodule // tb
